// >>> testbench/tb.sv
// self-checking bench for the path overhead and error statistics block
`timescale 1ns/1ps
`default_nettype none
`include "wps_map.svh"
module tb;
  logic mclk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, z3, z4, n1;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irqOutA, irqOutB, cgdBackReport;
  logic [1:0] bresp, rresp, lastResp;
  logic cgdLossIn, frameDone, snapshotPin, sendFrame = 0, lossReq = 0, pinReq = 0;
  logic [7:0] s1, p3;
  logic [10:0] l2, fl;
  logic [3:0] fp;
  logic [31:0] inc[5], cnt[5];
  int errors = 0, compares = 0;
  always #25 mclk = ~mclk;
  wps_pcs_model pm_u (.mclk(mclk), .sendFrame(sendFrame), .lossReq(lossReq), .pinReq(pinReq),
    .cgdLossIn(cgdLossIn), .frameDone(frameDone), .sectionParityMismatch(s1),
    .lineParityMismatchCount(l2), .pathParityMismatch(p3), .farPathErrValue(fp),
    .farLineErrValue(fl), .snapshotPin(snapshotPin));
  wps_path_stats #(.CGD_SET_CYC(20), .CGD_CLR_CYC(10)) dut_u (.mclk(mclk), .resetn(resetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cgdLossIn(cgdLossIn),
    .frameDone(frameDone), .sectionParityMismatch(s1), .lineParityMismatchCount(l2),
    .pathParityMismatch(p3), .farPathErrValue(fp), .farLineErrValue(fl),
    .snapshotPin(snapshotPin), .z3TxValue(z3), .z4TxValue(z4), .n1TxValue(n1),
    .cgdBackReport(cgdBackReport), .irqOutA(irqOutA), .irqOutB(irqOutB));
  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
    aw = 1'b1;
    w = 1'b1;
    // ready and valid are read before this edge's updates land
    while (aw || w || !bvalid) begin
      @(posedge mclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    chk({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ar;
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    ar = 1'b1;
    while (ar || !rvalid) begin
      @(posedge mclk);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end
    v = rdata;
    lastResp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rc
  task automatic frames(input int k);
    repeat (k) begin
      @(posedge mclk);
      sendFrame <= 1'b1;
      @(posedge mclk);
      sendFrame <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : frames
  task automatic std_all();
    for (int t = 0; t < 5; t++) begin
      rc(`WPS_REG_CNT_BASE + 8'(16 * t), {16'h0, cnt[t][31:16]});
      rc(`WPS_REG_CNT_BASE + 8'(16 * t + 4), {16'h0, cnt[t][15:0]});
    end
  endtask : std_all
  task automatic t_reset();
    chk({n1, z4, z3}, 32'h0);
    chk(cgdBackReport, 1'b1);
    rc(`WPS_REG_CTRL, 32'h0);
    rc(`WPS_REG_PERIOD, `WPS_PERIOD_RST);
    rd(8'hFC, d);
    chk({30'h0, lastResp}, `WPS_RESP_SLVERR);
    wr(`WPS_REG_TXOH, 32'h00A5C33C);
    repeat (2) @(posedge mclk);
    chk({n1, z4, z3}, 32'hA5C33C);
  endtask : t_reset
  task automatic t_cgd();
    repeat (30) @(posedge mclk);
    chk(cgdBackReport, 1'b0);
    lossReq <= 1'b1;
    repeat (10) @(posedge mclk);
    lossReq <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(cgdBackReport, 1'b0);
    rd(`WPS_REG_STATUS, d);
    chk(d & 32'h3, 32'h3);
    rd(`WPS_REG_STATUS, d);
    chk(d & 32'h3, 32'h0);
    wr(`WPS_REG_MASK, 32'h1);
    lossReq <= 1'b1;
    repeat (30) @(posedge mclk);
    chk({cgdBackReport, irqOutA}, 2'h3);
    wr(`WPS_REG_MASK, 32'h2);
    repeat (3) @(posedge mclk);
    chk({irqOutB, irqOutA}, 2'h2);
    lossReq <= 1'b0;
    repeat (25) @(posedge mclk);
    chk(cgdBackReport, 1'b0);
    wr(`WPS_REG_MASK, 32'h0);
  endtask : t_cgd
  task automatic t_counters();
    inc = '{$countones(8'h0F), 1536, $countones(8'h81), 8, 5};
    frames(3);
    foreach (cnt[t]) cnt[t] = 3 * inc[t];
    std_all();
    frames(1);
    for (int t = 0; t < 5; t++) begin
      rc(`WPS_REG_CNT_BASE + 8'(16 * t + 4), {16'h0, cnt[t][15:0]});
      cnt[t] += inc[t];
    end
    std_all();
    rd(`WPS_REG_STATUS, d);
    wr(`WPS_REG_CTRL, 32'h1);
    repeat (5) @(posedge mclk);
    for (int t = 0; t < 5; t++) begin
      rc(`WPS_REG_CNT_BASE + 8'(16 * t + 8), {16'h0, cnt[t][31:16]});
      rc(`WPS_REG_CNT_BASE + 8'(16 * t + 12), {16'h0, cnt[t][15:0]});
    end
    rd(`WPS_REG_STATUS, d);
    chk(d & 32'h4, 32'h4);
    wr(`WPS_REG_CTRL, 32'h1);
    repeat (5) @(posedge mclk);
    for (int t = 0; t < 5; t++) rc(`WPS_REG_CNT_BASE + 8'(16 * t + 12), 32'h0);
    wr(`WPS_REG_CTRL, 32'h78);
    frames(2);
    inc = '{1, 1, 1, 1, 5};
    foreach (cnt[t]) cnt[t] += 2 * inc[t];
    std_all();
  endtask : t_counters
  task automatic t_ticks();
    wr(`WPS_REG_PERIOD, 32'h8);
    rd(`WPS_REG_STATUS, d);
    wr(`WPS_REG_MASK, 32'h4);
    wr(`WPS_REG_CTRL, 32'h6);
    repeat (20) @(posedge mclk);
    chk(irqOutA, 1'b1);
    wr(`WPS_REG_CTRL, 32'h0);
    rd(`WPS_REG_STATUS, d);
    repeat (30) @(posedge mclk);
    rd(`WPS_REG_STATUS, d);
    chk(d & 32'h4, 32'h0);
    wr(`WPS_REG_CTRL, 32'h2);
    pinReq <= 1'b1;
    repeat (12) @(posedge mclk);
    rd(`WPS_REG_STATUS, d);
    chk(d & 32'h4, 32'h4);
    repeat (12) @(posedge mclk);
    rd(`WPS_REG_STATUS, d);
    chk(d & 32'h4, 32'h0);
    wr(`WPS_REG_MASK, 32'h8);
    wr(`WPS_REG_CTRL, 32'h1);
    repeat (5) @(posedge mclk);
    chk({irqOutB, irqOutA}, 2'h2);
  endtask : t_ticks
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_cgd();
    t_counters();
    t_ticks();
    give_verdict();
  end
  initial begin
    // the whole sequence needs some hundreds of cycles
    repeat (20000) @(posedge mclk);
    errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// >>> testbench/wps_pcs_model.sv
// receive-side source model: frame error figures, delineation loss and the tick pin
`timescale 1ns/1ps
`default_nettype none
module wps_pcs_model #(
  parameter logic [7:0] S1 = 8'h0F,
  parameter logic [10:0] L2 = 11'd1536,
  parameter logic [7:0] P3 = 8'h81,
  parameter logic [3:0] FP = 4'h8,
  parameter logic [10:0] FL = 11'd5
) (
  input wire logic mclk,
  input wire logic sendFrame,
  input wire logic lossReq,
  input wire logic pinReq,
  output logic cgdLossIn,
  output logic frameDone,
  output logic [7:0] sectionParityMismatch,
  output logic [10:0] lineParityMismatchCount,
  output logic [7:0] pathParityMismatch,
  output logic [3:0] farPathErrValue,
  output logic [10:0] farLineErrValue,
  output logic snapshotPin
);
  initial {cgdLossIn, frameDone, snapshotPin} = 3'h0;
  always @(posedge mclk) begin
    frameDone <= sendFrame;
    cgdLossIn <= lossReq;
    snapshotPin <= pinReq;
    if (sendFrame) begin // figures stay within 8 and 1536 a frame
      {sectionParityMismatch, lineParityMismatchCount, pathParityMismatch} <= {S1, L2, P3};
      {farPathErrValue, farLineErrValue} <= {FP, FL};
    end else begin
      // outside a frame the section and path figures are not held, so a stray sample shows up
      sectionParityMismatch <= ~sectionParityMismatch;
      pathParityMismatch <= ~pathParityMismatch;
    end
  end
endmodule : wps_pcs_model
`default_nettype wire

// >>> verilog/wps_cgd_monitor.sv
// persistence filter for loss of code group delineation
`timescale 1ns/1ps
`default_nettype none
`include "wps_map.svh"
module wps_cgd_monitor #(
  parameter int SET_CYC = `WPS_CGD_SET_CYC,
  parameter int CLR_CYC = `WPS_CGD_CLR_CYC,
  parameter int CNT_W = 17
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cgdLoss,
  output logic defect
);
  wps_pkg::wps_cgd_state_type state_q;
  logic [CNT_W-1:0] cnt_q;

  // reset lands in the defect state so the far end hears of it until delineation
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= wps_pkg::WPS_CGD_DEFECT;
      cnt_q <= '0;
    end else begin
      case (state_q)
        wps_pkg::WPS_CGD_CLEAR: begin
          cnt_q <= '0;
          if (cgdLoss) state_q <= wps_pkg::WPS_CGD_ONSET;
        end
        wps_pkg::WPS_CGD_ONSET: begin
          if (!cgdLoss) begin
            state_q <= wps_pkg::WPS_CGD_CLEAR;
          end else if (cnt_q == CNT_W'(SET_CYC)) begin
            state_q <= wps_pkg::WPS_CGD_DEFECT;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        wps_pkg::WPS_CGD_DEFECT: begin
          cnt_q <= '0;
          if (!cgdLoss) state_q <= wps_pkg::WPS_CGD_ABATE;
        end
        wps_pkg::WPS_CGD_ABATE: begin
          if (cgdLoss) begin
            state_q <= wps_pkg::WPS_CGD_DEFECT;
          end else if (cnt_q == CNT_W'(CLR_CYC)) begin
            state_q <= wps_pkg::WPS_CGD_CLEAR;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= wps_pkg::WPS_CGD_DEFECT;
      endcase
    end
  end

  // gray code puts the reported defect on bit 1 of the state
  assign defect = state_q[1];
endmodule : wps_cgd_monitor
`default_nettype wire

// >>> verilog/wps_err_counter.sv
// one error type: standard counter with shadow and saturating statistical counter
`timescale 1ns/1ps
`default_nettype none
module wps_err_counter #(
  parameter int INC_W = 11,
  parameter int CNT_W = 32
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [INC_W-1:0] incVal,
  input wire logic snapTick,
  input wire logic stdLatch,
  output logic [CNT_W-1:0] stdLive,
  output logic [CNT_W-1:0] stdShadow,
  output logic [CNT_W-1:0] statSnap
);
  logic [CNT_W-1:0] stat_q;
  logic [CNT_W:0] statSum;

  assign statSum = {1'b0, stat_q} + (CNT_W+1)'(incVal);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) stdLive <= '0;
    else stdLive <= stdLive + CNT_W'(incVal);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) stdShadow <= '0;
    else if (stdLatch) stdShadow <= stdLive;
  end

  // errors arriving with the tick open the new interval rather than being lost
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= '0;
      statSnap <= '0;
    end else if (snapTick) begin
      statSnap <= stat_q;
      stat_q <= CNT_W'(incVal);
    end else if (statSum[CNT_W]) begin
      stat_q <= '1;
    end else begin
      stat_q <= statSum[CNT_W-1:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  snap_copy_a: assert property (snapTick |=> statSnap == $past(stat_q))
    else $error("snapshot did not copy the statistical count");
  stat_sat_a: assert property ((stat_q == '1) && !snapTick |=> stat_q == '1)
    else $error("statistical counter wrapped");
  std_latch_a: assert property (stdLatch ##1 !stdLatch[*2] |-> stdShadow == $past(stdLive, 2))
    else $error("shadow changed without an upper read");
endmodule : wps_err_counter
`default_nettype wire

// >>> verilog/wps_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef WPS_MAP_SVH
`define WPS_MAP_SVH
`define WPS_ADDR_W 8
`define WPS_REG_CTRL 8'h00
`define WPS_REG_PERIOD 8'h04
`define WPS_REG_TXOH 8'h08
`define WPS_REG_STATUS 8'h0C
`define WPS_REG_MASK 8'h10
`define WPS_REG_CNT_BASE 8'h20
`define WPS_CNT_TYPES 5
`define WPS_CTRL_FORCE 0
`define WPS_CTRL_ENABLE 1
`define WPS_CTRL_SRC_INT 2
`define WPS_CTRL_B1_BLK 3
`define WPS_CTRL_B2_BLK 4
`define WPS_CTRL_B3_BLK 5
`define WPS_CTRL_REIP_BLK 6
`define WPS_CTRL_W 7
`define WPS_CTRL_RST 7'h00
`define WPS_PERIOD_RST 32'h0131_2D00
`define WPS_TXOH_RST 24'h00_0000
`define WPS_ST_CGD_LATCH 0
`define WPS_ST_CGD_PEND 1
`define WPS_ST_SNAP_PEND 2
`define WPS_ST_CGD_LIVE 3
`define WPS_ST_BACKREPORT 4
`define WPS_MASK_CGD_A 0
`define WPS_MASK_CGD_B 1
`define WPS_MASK_SNAP_A 2
`define WPS_MASK_SNAP_B 3
`define WPS_MASK_RST 4'h0
`define WPS_MCLK_KHZ 20000
`define WPS_CGD_SET_US 3000
`define WPS_CGD_CLR_US 1000
`define WPS_CGD_SET_CYC ((`WPS_CGD_SET_US * `WPS_MCLK_KHZ) / 1000)
`define WPS_CGD_CLR_CYC ((`WPS_CGD_CLR_US * `WPS_MCLK_KHZ + 999) / 1000)
`define WPS_RESP_OKAY 2'h0
`define WPS_RESP_SLVERR 2'h2
`endif

// >>> verilog/wps_path_stats.sv
// path overhead insertion, delineation alarm and error statistics with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "wps_map.svh"
module wps_path_stats #(
  parameter int CGD_SET_CYC = `WPS_CGD_SET_CYC,
  parameter int CGD_CLR_CYC = `WPS_CGD_CLR_CYC,
  parameter logic [31:0] PERIOD_RST = `WPS_PERIOD_RST
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cgdLossIn,
  input wire logic frameDone,
  input wire logic [7:0] sectionParityMismatch,
  input wire logic [10:0] lineParityMismatchCount,
  input wire logic [7:0] pathParityMismatch,
  input wire logic [3:0] farPathErrValue,
  input wire logic [10:0] farLineErrValue,
  input wire logic snapshotPin,
  output logic [7:0] z3TxValue,
  output logic [7:0] z4TxValue,
  output logic [7:0] n1TxValue,
  output logic cgdBackReport,
  output logic irqOutA,
  output logic irqOutB
);
  localparam int NT = `WPS_CNT_TYPES;

  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [`WPS_CTRL_W-1:0] ctrl_q;
  logic [31:0] period_q;
  logic [3:0] mask_q;
  logic cgdLatched_q;
  logic cgdPend_q;
  logic snapPend_q;
  logic forceTick_q;
  logic periodTick_q;
  logic gpioTick_q;
  logic snapTick_q;
  logic [31:0] periodCnt_q;
  logic [2:0] pinSync_q;
  logic pinLevel_q;
  logic cgdDefect;
  logic wrDo;
  logic rdDo;
  logic stReadClr;
  logic [31:0] rdMux;
  logic rdErr;
  logic [10:0] incVal [NT];
  logic [31:0] stdLive [NT];
  logic [31:0] stdShadow [NT];
  logic [31:0] statSnap [NT];
  logic [NT-1:0] stdLatch;
  logic [7:0] cntOff;
  logic [2:0] cntType;

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  assign wrDo = !awready && !wready && !bvalid;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `WPS_RESP_OKAY;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (wrDo) begin
        bvalid <= 1'b1;
        bresp <= (awAddr_q <= `WPS_REG_MASK && awAddr_q[1:0] == 2'h0 &&
                  awAddr_q != `WPS_REG_STATUS) ? `WPS_RESP_OKAY : `WPS_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] wpsMerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction : wpsMerge

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `WPS_CTRL_RST;
      period_q <= PERIOD_RST;
      mask_q <= `WPS_MASK_RST;
      {n1TxValue, z4TxValue, z3TxValue} <= `WPS_TXOH_RST;
    end else if (wrDo) begin
      case (awAddr_q)
        `WPS_REG_CTRL: ctrl_q <= `WPS_CTRL_W'(wpsMerge({25'h0, ctrl_q}, wData_q, wStrb_q))
                                 & ~(`WPS_CTRL_W'(1) << `WPS_CTRL_FORCE);
        `WPS_REG_PERIOD: period_q <= wpsMerge(period_q, wData_q, wStrb_q);
        `WPS_REG_TXOH: {n1TxValue, z4TxValue, z3TxValue} <=
          24'(wpsMerge({8'h00, n1TxValue, z4TxValue, z3TxValue}, wData_q, wStrb_q));
        `WPS_REG_MASK: mask_q <= 4'(wpsMerge({28'h0, mask_q}, wData_q, wStrb_q));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel: one cycle from address to data

  assign rdDo = arvalid && arready;
  assign cntOff = araddr - `WPS_REG_CNT_BASE;
  assign cntType = cntOff[6:4];
  assign stReadClr = rdDo && araddr == `WPS_REG_STATUS;

  always_comb begin
    rdMux = 32'h0000_0000;
    rdErr = 1'b0;
    stdLatch = '0;
    if (araddr[1:0] != 2'h0) begin
      rdErr = 1'b1;
    end else if (araddr >= `WPS_REG_CNT_BASE) begin
      if (cntType < 3'(NT) && !cntOff[7]) begin
        case (cntOff[3:2])
          2'h0: begin
            rdMux = {16'h0000, stdLive[cntType][31:16]};
            stdLatch[cntType] = rdDo;
          end
          2'h1: rdMux = {16'h0000, stdShadow[cntType][15:0]};
          2'h2: rdMux = {16'h0000, statSnap[cntType][31:16]};
          default: rdMux = {16'h0000, statSnap[cntType][15:0]};
        endcase
      end else begin
        rdErr = 1'b1;
      end
    end else begin
      case (araddr)
        `WPS_REG_CTRL: rdMux = {25'h0, ctrl_q};
        `WPS_REG_PERIOD: rdMux = period_q;
        `WPS_REG_TXOH: rdMux = {8'h00, n1TxValue, z4TxValue, z3TxValue};
        `WPS_REG_STATUS: rdMux = {27'h0, cgdBackReport, cgdDefect, snapPend_q, cgdPend_q,
                                  cgdLatched_q};
        `WPS_REG_MASK: rdMux = {28'h0, mask_q};
        default: rdErr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `WPS_RESP_OKAY;
    end else if (rdDo) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdErr ? `WPS_RESP_SLVERR : `WPS_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // delineation loss alarm; a new event beats the clear-on-read

  wps_cgd_monitor #(.SET_CYC(CGD_SET_CYC), .CLR_CYC(CGD_CLR_CYC)) cgdMon (
    .mclk(mclk),
    .resetn(resetn),
    .cgdLoss(cgdLossIn),
    .defect(cgdDefect)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cgdLatched_q <= 1'b0;
      cgdPend_q <= 1'b0;
      snapPend_q <= 1'b0;
    end else begin
      cgdLatched_q <= (cgdLatched_q && !stReadClr) || cgdLossIn;
      cgdPend_q <= (cgdPend_q && !stReadClr) || cgdLossIn;
      snapPend_q <= (snapPend_q && !stReadClr) || snapTick_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cgdBackReport <= 1'b1;
      irqOutA <= 1'b0;
      irqOutB <= 1'b0;
    end else begin
      cgdBackReport <= cgdDefect;
      irqOutA <= (cgdPend_q && mask_q[`WPS_MASK_CGD_A]) ||
                 (snapPend_q && mask_q[`WPS_MASK_SNAP_A]);
      irqOutB <= (cgdPend_q && mask_q[`WPS_MASK_CGD_B]) ||
                 (snapPend_q && mask_q[`WPS_MASK_SNAP_B]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // snapshot tick sources; mclk is the recovered receive clock, so the period drifts with it

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      forceTick_q <= 1'b0;
    end else begin
      forceTick_q <= wrDo && awAddr_q == `WPS_REG_CTRL && wStrb_q[0] &&
                     wData_q[`WPS_CTRL_FORCE];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periodCnt_q <= 32'h0000_0000;
      periodTick_q <= 1'b0;
    end else if (ctrl_q[`WPS_CTRL_ENABLE] && ctrl_q[`WPS_CTRL_SRC_INT]) begin
      // a zero period behaves as one so the timer never stalls
      if (periodCnt_q + 32'h0000_0001 >= period_q) begin
        periodCnt_q <= 32'h0000_0000;
        periodTick_q <= 1'b1;
      end else begin
        periodCnt_q <= periodCnt_q + 32'h0000_0001;
        periodTick_q <= 1'b0;
      end
    end else begin
      periodCnt_q <= 32'h0000_0000;
      periodTick_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinSync_q <= 3'h0;
      pinLevel_q <= 1'b0;
      gpioTick_q <= 1'b0;
    end else begin
      pinSync_q <= {pinSync_q[1:0], snapshotPin};
      if (pinSync_q[1] == pinSync_q[2]) pinLevel_q <= pinSync_q[2];
      gpioTick_q <= pinSync_q[1] && pinSync_q[2] && !pinLevel_q &&
                    ctrl_q[`WPS_CTRL_ENABLE] && !ctrl_q[`WPS_CTRL_SRC_INT];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) snapTick_q <= 1'b0;
    else snapTick_q <= forceTick_q || periodTick_q || gpioTick_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-frame increments and counters

  function automatic logic [10:0] wpsOnes(input logic [7:0] v);
    logic [10:0] n;
    n = 11'h000;
    for (int i = 0; i < 8; i++) n = n + 11'(v[i]);
    return n;
  endfunction : wpsOnes

  always_comb begin
    incVal[0] = 11'h000;
    incVal[1] = 11'h000;
    incVal[2] = 11'h000;
    incVal[3] = 11'h000;
    incVal[4] = 11'h000;
    if (frameDone) begin
      incVal[0] = ctrl_q[`WPS_CTRL_B1_BLK] ? 11'(|sectionParityMismatch) :
                  wpsOnes(sectionParityMismatch);
      incVal[1] = ctrl_q[`WPS_CTRL_B2_BLK] ? 11'(|lineParityMismatchCount) :
                  lineParityMismatchCount;
      incVal[2] = ctrl_q[`WPS_CTRL_B3_BLK] ? 11'(|pathParityMismatch) :
                  wpsOnes(pathParityMismatch);
      incVal[3] = ctrl_q[`WPS_CTRL_REIP_BLK] ? 11'(|farPathErrValue) :
                  11'(farPathErrValue);
      incVal[4] = farLineErrValue;
    end
  end

  for (genvar g = 0; g < NT; g++) begin : gCnt
    wps_err_counter #(.INC_W(11), .CNT_W(32)) errCnt (
      .mclk(mclk),
      .resetn(resetn),
      .incVal(incVal[g]),
      .snapTick(snapTick_q),
      .stdLatch(stdLatch[g]),
      .stdLive(stdLive[g]),
      .stdShadow(stdShadow[g]),
      .statSnap(statSnap[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  z3z4_write_a: assert property (wrDo && awAddr_q == `WPS_REG_TXOH && wStrb_q[1:0] == 2'h3
    |=> z3TxValue == $past(wData_q[7:0]) && z4TxValue == $past(wData_q[15:8]))
    else $error("z3/z4 transmit value not taken");
  n1_write_a: assert property (wrDo && awAddr_q == `WPS_REG_TXOH && wStrb_q[2]
    |=> n1TxValue == $past(wData_q[23:16]))
    else $error("n1 transmit value not taken");
  cgd_pend_a: assert property (cgdLossIn |=> cgdPend_q && cgdLatched_q)
    else $error("delineation loss not flagged");
  cgd_irq_a: assert property (cgdPend_q && mask_q[`WPS_MASK_CGD_A] |=> irqOutA)
    else $error("delineation interrupt A missing");
  report_onset_a: assert property ($rose(cgdBackReport) |-> $past(cgdLossIn, 2))
    else $error("back-report rose without loss");
  report_release_a: assert property ($fell(cgdBackReport) |-> !$past(cgdLossIn, 2))
    else $error("back-report fell during loss");
  force_tick_a: assert property (wrDo && awAddr_q == `WPS_REG_CTRL && wStrb_q[0]
    && wData_q[`WPS_CTRL_FORCE] |=> ##1 snapTick_q ##1 snapPend_q)
    else $error("forced snapshot missing");
  gpio_tick_a: assert property ($rose(pinLevel_q) && ctrl_q[`WPS_CTRL_ENABLE]
    && !ctrl_q[`WPS_CTRL_SRC_INT] && $stable(ctrl_q) |=> snapTick_q)
    else $error("pin edge gave no snapshot");
  period_tick_a: assert property (periodTick_q |=> snapTick_q ##0 periodCnt_q <= 32'h1)
    else $error("periodic snapshot missing");

  cgd_report_c: cover property ($fell(cgdBackReport));
  periodic_c: cover property (periodTick_q ##[1:40] periodTick_q);
  gpio_c: cover property (gpioTick_q);
  irq_b_c: cover property ($rose(irqOutB));
endmodule : wps_path_stats
`default_nettype wire

// >>> verilog/wps_pkg.sv
// shared types of the path overhead and error statistics block
`default_nettype none
package wps_pkg;
  typedef enum logic [1:0] {
    WPS_CGD_CLEAR = 2'h0,
    WPS_CGD_ONSET = 2'h1,
    WPS_CGD_DEFECT = 2'h3,
    WPS_CGD_ABATE = 2'h2
  } wps_cgd_state_type;
endpackage : wps_pkg
`default_nettype wire
